/* File: design/wake_pkg.sv */
// package: register map, field positions and timing for the low-power wake controller
package wake_pkg;
  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_INTERRUPT_OPTION = 8'hc8;
  localparam logic [7:0] ADDR_EVENT_ENABLE = 8'hd0;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'hd4;
  localparam logic [7:0] ADDR_WAKE_STATUS = 8'hd8;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int OPT_LEVEL_SRC1 = 6;
  localparam int OPT_RISING_SRC2 = 5;
  localparam int OPT_GLOBAL_EN = 4;
  localparam logic [7:0] OPT_RESET = 8'h00;
  localparam int EN_TIMER = 0;
  localparam int EN_CONVERTER = 1;
  localparam int EN_RELOAD_OVF = 2;
  localparam int EN_COMPARE = 3;
  localparam int EN_RECEIVE = 4;
  localparam int EN_TRANSMIT = 5;
  localparam logic [7:0] EN_RESET = 8'h00;
  localparam int PWR_OSC_SELECT = 0;
  localparam logic [7:0] PWR_RESET = 8'h00;
  localparam int PORT_PINS = 12;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int STAB_TIME_US = 64;
  localparam int STAB_CYCLES = (CLK_HZ / 1000000) * STAB_TIME_US;
  localparam logic [11:0] STAB_LAST = 12'(STAB_CYCLES - 1);
  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {MODE_NORMAL, MODE_IRQ, MODE_NMI} core_mode_t;
  typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_STOP, ST_STAB} power_state_t;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
endpackage

/* File: design/source_if.sv */
// interface: configuration in, interrupt source requests out, between controller and router
`timescale 1ns/1ps
interface source_if;
  logic level_src1;
  logic rising_src2;
  logic [7:0] event_en;
  logic ack;
  logic [2:0] ack_vector;
  logic [4:1] src_req;
  logic nmi_req;
  modport router (input level_src1, rising_src2, event_en, ack, ack_vector,
                  output src_req, nmi_req);
  modport ctrl (output level_src1, rising_src2, event_en, ack, ack_vector,
                input src_req, nmi_req);
endinterface

/* File: design/source_router.sv */
// module: routes peripheral and pin events onto the nmi and four maskable sources
`timescale 1ns/1ps
module source_router
  import wake_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // peripheral event flags, same clock
  input wire logic timer_zero_flag,
  input wire logic converter_done_flag,
  input wire logic spi_done_flag,
  input wire logic reload_overflow_flag,
  input wire logic compare_match_flag,
  input wire logic byte_received_flag,
  input wire logic byte_sent_flag,
  // pins from outside, asynchronous
  input wire logic nmi_pin_n,
  input wire logic [wake_pkg::PORT_PINS-1:0] port_pins,
  input wire logic [wake_pkg::PORT_PINS-1:0] port_option,
  input wire logic [wake_pkg::PORT_PINS-1:0] port_data,
  // link to controller
  source_if.router src
);
  logic [PORT_PINS:0] meta_q, sync_q, prev_q;
  logic spi_prev_q, src1_latch_q, src2_latch_q, nmi_latch_q;
  logic pin_rise, pin_fall, spi_edge, nmi_edge;
  logic [PORT_PINS-1:0] pin_sel;

  // ----------------------------------------------------------------
  // two-stage synchronisers, then a history stage for edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end else begin
      meta_q <= {nmi_pin_n, port_pins};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // a pin takes part only when set up as input with interrupt
  assign pin_sel = port_option & ~port_data;
  assign pin_rise = |(pin_sel & sync_q[PORT_PINS-1:0] & ~prev_q[PORT_PINS-1:0]);
  assign pin_fall = |(pin_sel & ~sync_q[PORT_PINS-1:0] & prev_q[PORT_PINS-1:0]);
  assign nmi_edge = prev_q[PORT_PINS] & ~sync_q[PORT_PINS];
  assign spi_edge = spi_done_flag & ~spi_prev_q;

  // edge latches; a new edge in the acknowledge cycle wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spi_prev_q <= 1'b0;
      src1_latch_q <= 1'b0;
      src2_latch_q <= 1'b0;
      nmi_latch_q <= 1'b0;
    end else begin
      spi_prev_q <= spi_done_flag;
      if (spi_edge)
        src1_latch_q <= 1'b1;
      else if (src.ack && src.ack_vector == 3'h1)
        src1_latch_q <= 1'b0;
      if (src.rising_src2 ? pin_rise : pin_fall)
        src2_latch_q <= 1'b1;
      else if (src.ack && src.ack_vector == 3'h2)
        src2_latch_q <= 1'b0;
      if (nmi_edge)
        nmi_latch_q <= 1'b1;
      else if (src.ack && src.ack_vector == 3'h0)
        nmi_latch_q <= 1'b0;
    end
  end

  // level sources pass straight through: source 1 ungated, sources 3 and 4 via their enable gates
  assign src.src_req[1] = src.level_src1 ? spi_done_flag : src1_latch_q;
  assign src.src_req[2] = src2_latch_q;
  assign src.src_req[3] = (timer_zero_flag & src.event_en[EN_TIMER])
    | (reload_overflow_flag & src.event_en[EN_RELOAD_OVF])
    | (compare_match_flag & src.event_en[EN_COMPARE]);
  assign src.src_req[4] = (converter_done_flag & src.event_en[EN_CONVERTER])
    | (byte_received_flag & src.event_en[EN_RECEIVE])
    | (byte_sent_flag & src.event_en[EN_TRANSMIT]);
  assign src.nmi_req = nmi_latch_q;
endmodule

/* File: design/low_power_wake_control.sv */
// module: wait/stop power state control, wake-up and interrupt arbitration with axi4-lite regs
//
// Notes on behaviour
// - global enable masks all sources except the non-maskable one.
// - basic timer overflow, gated by its enable, drives maskable source 3.
// - converter end of conversion, gated by its enable, drives source 4.
// - wait halts the core; clock and peripherals keep running.
// - an enabled peripheral interrupt ends the wait state.
// - leaving wait resumes at once, no stabilisation delay.
// - stop halts the core and oscillator until interrupt or reset.
// - leaving stop waits a stabilisation delay before the first instruction.
// - with the watchdog active, stop behaves as wait.
// - any reset in a low-power state runs the normal reset.
// - from main routine the waking interrupt is serviced first.
// - from the nmi handler, wake continues with the next instruction.
// - from a maskable handler woken by maskable, the handler continues.
// - from a maskable handler woken by nmi, the nmi handler runs first.
// - with global enable clear, nothing but reset wakes the device.
// - wait and stop are skipped while an enabled request is pending.
// - interrupts and wake-ups never change the oscillator selection.
// - fixed priority, source 1 highest; maskable handlers never preempt each other.
// - the interrupt option register clears to zero on reset.
`timescale 1ns/1ps
module low_power_wake_control
  import wake_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core sequencer
  input wire logic wait_exec,
  input wire logic stop_exec,
  input wire wake_pkg::core_mode_t core_mode,
  input wire logic irq_ack,
  input wire logic [2:0] ack_vector,
  output logic core_halt,
  output logic resume_next,
  output logic irq_valid,
  output logic [2:0] irq_vector,
  // oscillator and watchdog
  input wire logic wdg_hw_option,
  input wire logic wdg_sw_enable,
  output logic osc_enable,
  output logic osc_select,
  // peripheral event flags
  input wire logic timer_zero_flag,
  input wire logic converter_done_flag,
  input wire logic spi_done_flag,
  input wire logic reload_overflow_flag,
  input wire logic compare_match_flag,
  input wire logic byte_received_flag,
  input wire logic byte_sent_flag,
  // pins
  input wire logic nmi_pin_n,
  input wire logic [wake_pkg::PORT_PINS-1:0] port_pins,
  input wire logic [wake_pkg::PORT_PINS-1:0] port_option,
  input wire logic [wake_pkg::PORT_PINS-1:0] port_data
);
  import wake_pkg::*;

  source_if src ();
  power_state_t state_q, state_d;
  logic [7:0] interrupt_option_q, event_enable_q, power_control_q;
  logic [11:0] stab_cnt_q;
  logic [7:0] aw_addr_q, ar_addr;
  logic [31:0] w_data_q;
  logic w_lane0_q, aw_full_q, w_full_q;
  logic wr_do, aw_hs, w_hs, ar_hs, wr_mapped;
  logic aw_full_d, w_full_d, bvalid_d, rvalid_d;
  logic global_en, grant_any, wake_ev, lp_cmd, to_run;
  logic [2:0] grant_vec;

  // ----------------------------------------------------------------
  // source routing
  // ----------------------------------------------------------------
  assign global_en = interrupt_option_q[OPT_GLOBAL_EN];
  assign src.level_src1 = interrupt_option_q[OPT_LEVEL_SRC1];
  assign src.rising_src2 = interrupt_option_q[OPT_RISING_SRC2];
  assign src.event_en = event_enable_q;
  assign src.ack = irq_ack;
  assign src.ack_vector = ack_vector;

  source_router router (
    .aclk(aclk),
    .aresetn(aresetn),
    .timer_zero_flag(timer_zero_flag),
    .converter_done_flag(converter_done_flag),
    .spi_done_flag(spi_done_flag),
    .reload_overflow_flag(reload_overflow_flag),
    .compare_match_flag(compare_match_flag),
    .byte_received_flag(byte_received_flag),
    .byte_sent_flag(byte_sent_flag),
    .nmi_pin_n(nmi_pin_n),
    .port_pins(port_pins),
    .port_option(port_option),
    .port_data(port_data),
    .src(src.router)
  );

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  // nmi beats everything except a running nmi handler; maskable sources only
  // from the main routine, so one maskable handler never preempts another
  always_comb begin
    grant_any = 1'b0;
    grant_vec = 3'h0;
    if (src.nmi_req && core_mode != MODE_NMI) begin
      grant_any = 1'b1;
      grant_vec = 3'h0;
    end else if (global_en && core_mode == MODE_NORMAL) begin
      if (src.src_req[1]) begin
        grant_any = 1'b1;
        grant_vec = 3'h1;
      end else if (src.src_req[2]) begin
        grant_any = 1'b1;
        grant_vec = 3'h2;
      end else if (src.src_req[3]) begin
        grant_any = 1'b1;
        grant_vec = 3'h3;
      end else if (src.src_req[4]) begin
        grant_any = 1'b1;
        grant_vec = 3'h4;
      end
    end
  end

  // wake-up needs the global enable even for the nmi
  assign wake_ev = global_en && (src.nmi_req || (|src.src_req));
  assign lp_cmd = wait_exec || stop_exec;

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (lp_cmd && !grant_any) begin
          if (stop_exec && !(wdg_hw_option || wdg_sw_enable))
            state_d = ST_STOP;
          else
            state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (wake_ev)
          state_d = ST_RUN;
      end
      ST_STOP: begin
        if (wake_ev)
          state_d = ST_STAB;
      end
      ST_STAB: begin
        if (stab_cnt_q == STAB_LAST)
          state_d = ST_RUN;
      end
      default: state_d = ST_RUN;
    endcase
  end

  // synchronous reset returns everything to run, from any state
  always_ff @(posedge aclk) begin
    if (!aresetn)
      state_q <= ST_RUN;
    else
      state_q <= state_d;
  end

  // stabilisation count runs only while the oscillator restarts
  always_ff @(posedge aclk) begin
    if (!aresetn)
      stab_cnt_q <= 12'h000;
    else if (state_q == ST_STAB)
      stab_cnt_q <= stab_cnt_q + 12'h001;
    else
      stab_cnt_q <= 12'h000;
  end

  assign to_run = (state_d == ST_RUN);

  // core and oscillator controls, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_halt <= 1'b0;
      osc_enable <= 1'b1;
      resume_next <= 1'b0;
      irq_valid <= 1'b0;
      irq_vector <= 3'h0;
    end else begin
      core_halt <= !to_run;
      osc_enable <= (state_d != ST_STOP);
      // one pulse when the core may fetch again, after a skip or a wake
      resume_next <= to_run && (lp_cmd && state_q == ST_RUN ? 1'b1 : state_q != ST_RUN);
      // the request shown after wake follows the core mode, which gives the
      // documented restart order for main, nmi and maskable handlers
      irq_valid <= to_run && grant_any && !irq_ack;
      irq_vector <= grant_vec;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write path
  // ----------------------------------------------------------------
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign wr_do = aw_full_q && w_full_q && !s_axi_bvalid;
  assign aw_full_d = aw_hs || (aw_full_q && !wr_do);
  assign w_full_d = w_hs || (w_full_q && !wr_do);
  assign bvalid_d = wr_do || (s_axi_bvalid && !s_axi_bready);
  assign wr_mapped = (aw_addr_q == ADDR_INTERRUPT_OPTION) || (aw_addr_q == ADDR_EVENT_ENABLE)
    || (aw_addr_q == ADDR_POWER_CONTROL) || (aw_addr_q == ADDR_WAKE_STATUS);

  // address and data are held separately, so either may arrive first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_lane0_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      if (aw_hs)
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      if (w_hs) begin
        w_data_q <= s_axi_wdata;
        w_lane0_q <= s_axi_wstrb[0];
      end
      s_axi_awready <= !aw_full_d && !bvalid_d;
      s_axi_wready <= !w_full_d && !bvalid_d;
      s_axi_bvalid <= bvalid_d;
      if (wr_do)
        s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_DECERR;
    end
  end

  // register writes; only byte lane 0 carries data, the status word ignores writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_option_q <= OPT_RESET;
      event_enable_q <= EN_RESET;
      power_control_q <= PWR_RESET;
    end else if (wr_do && w_lane0_q) begin
      case (aw_addr_q)
        ADDR_INTERRUPT_OPTION: interrupt_option_q <= w_data_q[7:0];
        ADDR_EVENT_ENABLE: event_enable_q <= w_data_q[7:0];
        ADDR_POWER_CONTROL: power_control_q <= w_data_q[7:0];
        default: ;
      endcase
    end
  end

  // oscillator choice is only ever changed by software
  always_ff @(posedge aclk) begin
    if (!aresetn)
      osc_select <= 1'b0;
    else
      osc_select <= power_control_q[PWR_OSC_SELECT];
  end

  // ----------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign ar_addr = {s_axi_araddr[7:2], 2'b00};
  assign rvalid_d = ar_hs || (s_axi_rvalid && !s_axi_rready);

  // the option register is write-only and reads back as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !rvalid_d && !ar_hs;
      s_axi_rvalid <= rvalid_d;
      if (ar_hs) begin
        s_axi_rresp <= RESP_OKAY;
        case (ar_addr)
          ADDR_INTERRUPT_OPTION: s_axi_rdata <= 32'h0000_0000;
          ADDR_EVENT_ENABLE: s_axi_rdata <= {24'h00_0000, event_enable_q};
          ADDR_POWER_CONTROL: s_axi_rdata <= {24'h00_0000, power_control_q};
          ADDR_WAKE_STATUS: s_axi_rdata <= {24'h00_0000, src.nmi_req, src.src_req,
                                            1'b0, state_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_DECERR;
          end
        endcase
      end
    end
  end
endmodule

/* File: test/wake_monitor.sv */
// checker: port timing of the wake controller
`timescale 1ns/1ps
module wake_monitor
  import wake_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // core link
  input wire logic wait_exec,
  input wire logic stop_exec,
  input wire wake_pkg::core_mode_t core_mode,
  input wire logic irq_ack,
  input wire logic core_halt,
  input wire logic resume_next,
  input wire logic irq_valid,
  input wire logic [2:0] irq_vector,
  // oscillator, watchdog, bus
  input wire logic wdg_hw_option,
  input wire logic wdg_sw_enable,
  input wire logic osc_enable,
  input wire logic osc_select,
  input wire logic s_axi_bvalid
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----------
  // stabilisation timing
  // ----------
  logic stopped_q;
  logic [11:0] stab_q;
  // marks a halt that came from stop, so wait wake-ups are not timed
  always_ff @(posedge aclk) begin
    if (!aresetn || !core_halt) stopped_q <= 1'b0;
    else if (!osc_enable) stopped_q <= 1'b1;
  end
  // halted cycles with the oscillator back on; saturates rather than wrap
  always_ff @(posedge aclk) begin
    if (!aresetn || !osc_enable || !core_halt) stab_q <= 12'h000;
    else if (stab_q != 12'hfff) stab_q <= stab_q + 12'h001;
  end
  // ----------
  // assertions
  // ----------
  halt_no_irq_a: assert property (core_halt |-> !irq_valid)
    else $error("request while halted");
  stop_osc_off_a: assert property (!osc_enable |-> core_halt && !irq_valid)
    else $error("oscillator off while running");
  wdg_stop_wait_a: assert property (stop_exec && !core_halt && (wdg_hw_option || wdg_sw_enable)
    |=> osc_enable ##1 osc_enable)
    else $error("stop honoured with watchdog on");
  skip_pending_a: assert property ((wait_exec || stop_exec) && irq_valid && !irq_ack && !core_halt
    |=> !core_halt && resume_next)
    else $error("low-power command not skipped");
  wake_resume_a: assert property ($fell(core_halt) |-> resume_next)
    else $error("wake without resume");
  resume_pulse_a: assert property (resume_next |=> !resume_next)
    else $error("resume longer than one cycle");
  stab_delay_a: assert property ($fell(core_halt) && stopped_q
    |-> stab_q >= STAB_CYCLES - 2 && stab_q <= STAB_CYCLES + 2)
    else $error("stabilisation length wrong");
  osc_sel_keep_a: assert property ($changed(osc_select) |-> $past(s_axi_bvalid))
    else $error("oscillator selection changed");
  main_only_a: assert property ($rose(irq_valid) && irq_vector != 3'h0
    |-> $past(core_mode) == MODE_NORMAL)
    else $error("maskable request outside main");
  ack_drops_a: assert property (irq_ack && irq_valid |=> !irq_valid)
    else $error("request held after ack");
  stop_wake_c: cover property ($fell(core_halt) && stopped_q);
  wait_wake_c: cover property ($fell(core_halt) && !stopped_q);
  skip_c: cover property ((wait_exec || stop_exec) && irq_valid && !core_halt);
endmodule
bind low_power_wake_control wake_monitor u_mon (.*);

/* File: test/core_model.sv */
// partner model: core sequencer acknowledging service requests
`timescale 1ns/1ps
module core_model
  import wake_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // controller side
  input wire logic irq_valid,
  input wire logic [2:0] irq_vector,
  input wire logic core_halt,
  output logic irq_ack,
  output logic [2:0] ack_vector,
  // held low by the bench to make the core slow to answer
  input wire logic ack_en
);
  // one ack per request; a halted core fetches nothing, so never acks
  always_ff @(posedge aclk) begin
    if (!aresetn || irq_ack || core_halt || !ack_en || !irq_valid) begin
      irq_ack <= 1'b0;
      ack_vector <= ~irq_vector;
    end else begin
      irq_ack <= 1'b1;
      ack_vector <= irq_vector;
    end
  end
endmodule

/* File: test/test_low_power_wake_control.sv */
// testbench: register, wake-up, skip and priority sequences
`timescale 1ns/1ps
module test_low_power_wake_control;
  import wake_pkg::*;
  // ----------
  // signals
  // ----------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic wait_exec = 1'b0, stop_exec = 1'b0, irq_ack, ack_en = 1'b0;
  core_mode_t core_mode = MODE_NORMAL;
  logic [2:0] ack_vector, irq_vector;
  logic core_halt, resume_next, irq_valid, osc_enable, osc_select;
  logic wdg_hw_option = 1'b0, wdg_sw_enable = 1'b0, nmi_pin_n = 1'b1;
  logic timer_zero_flag = 1'b0, converter_done_flag = 1'b0, spi_done_flag = 1'b0;
  logic reload_overflow_flag = 1'b0, compare_match_flag = 1'b0;
  logic byte_received_flag = 1'b0, byte_sent_flag = 1'b0;
  logic [PORT_PINS-1:0] port_pins = 12'hfff, port_option = 12'h001, port_data = 12'h000;
  int compares = 0, miscompares = 0, n, i;
  low_power_wake_control u_dut (.*);
  core_model u_core (.*);
  // free-running clock
  always #20 aclk = ~aclk;
  // ----------
  // tasks
  // ----------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic hang();
    chk(0, 1, "wait ran out");
    complete_run();
  endtask
  // bounded wait: 1 halt low, 2 request up, 3 ack seen
  task automatic till(input int sel, input int lim, output int cnt);
    for (cnt = 0; ; cnt++) begin
      if (cnt == lim) hang();
      @(posedge aclk);
      if ((sel == 1 && core_halt === 1'b0) || (sel == 2 && irq_valid === 1'b1) ||
          (sel == 3 && irq_ack === 1'b1)) break;
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; ; n++) begin
      if (n == 50) hang();
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er, "bresp");
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; ; n++) begin
      if (n == 50) hang();
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h000000, ed}, "rdata");
    chk(s_axi_rresp, er, "rresp");
  endtask
  // one-cycle low-power command, returns with its effect settled
  task automatic cmd(input logic stop);
    if (stop) stop_exec <= 1'b1;
    else wait_exec <= 1'b1;
    @(posedge aclk);
    stop_exec <= 1'b0;
    wait_exec <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic take_irq(input logic [2:0] v);
    ack_en <= 1'b1;
    till(2, 40, n);
    chk(irq_vector, v, "vector");
    till(3, 40, n);
    ack_en <= 1'b0;
    // let an edge pass so a following call never re-raises ack_en in this step
    @(posedge aclk);
  endtask
  // ----------
  // sequence
  // ----------
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(ADDR_INTERRUPT_OPTION, 8'h00, RESP_OKAY);
    axi_rd(8'he0, 8'h00, RESP_DECERR);
    axi_wr(8'he0, 8'hff, RESP_DECERR);
    axi_wr(ADDR_EVENT_ENABLE, 8'h3f, RESP_OKAY);
    axi_rd(ADDR_EVENT_ENABLE, 8'h3f, RESP_OKAY);
    $display("test regs done");
    timer_zero_flag <= 1'b1;
    repeat (10) @(posedge aclk);
    chk(irq_valid, 0, "masked");
    axi_wr(ADDR_INTERRUPT_OPTION, 8'h10, RESP_OKAY);
    take_irq(3'h3);
    timer_zero_flag <= 1'b0;
    repeat (4) @(posedge aclk);
    $display("test mask done");
    {spi_done_flag, reload_overflow_flag, compare_match_flag, converter_done_flag} <= 4'hf;
    {byte_received_flag, byte_sent_flag} <= 2'h3;
    port_pins <= 12'hffe;
    repeat (8) @(posedge aclk);
    take_irq(3'h1);
    take_irq(3'h2);
    take_irq(3'h3);
    {reload_overflow_flag, compare_match_flag} <= 2'h0;
    repeat (4) @(posedge aclk);
    take_irq(3'h4);
    {converter_done_flag, byte_received_flag, byte_sent_flag, spi_done_flag} <= 4'h0;
    repeat (4) @(posedge aclk);
    // level mode on source 1 re-requests after ack; rising edge mode on source 2
    axi_wr(ADDR_INTERRUPT_OPTION, 8'h70, RESP_OKAY);
    {spi_done_flag, port_pins} <= {1'b1, 12'hfff};
    take_irq(3'h1);
    take_irq(3'h1);
    spi_done_flag <= 1'b0;
    repeat (2) @(posedge aclk);
    take_irq(3'h2);
    repeat (4) @(posedge aclk);
    $display("test priority done");
    cmd(1'b0);
    chk({core_halt, osc_enable}, 2'b11, "wait");
    repeat (3) @(posedge aclk);
    converter_done_flag <= 1'b1;
    till(1, 3, n);
    chk(resume_next, 1, "resume");
    take_irq(3'h4);
    converter_done_flag <= 1'b0;
    repeat (4) @(posedge aclk);
    $display("test wait done");
    axi_wr(ADDR_POWER_CONTROL, 8'h01, RESP_OKAY);
    cmd(1'b1);
    chk({core_halt, osc_enable}, 2'b10, "stop");
    nmi_pin_n <= 1'b0;
    till(1, 2000, n);
    chk(n >= STAB_CYCLES && n < STAB_CYCLES + 12, 1, "stab length");
    chk(osc_select, 1, "osc select");
    take_irq(3'h0);
    nmi_pin_n <= 1'b1;
    $display("test stop done");
    for (i = 0; i < 2; i++) begin
      wdg_hw_option <= (i == 0);
      wdg_sw_enable <= (i == 1);
      cmd(1'b1);
      chk({core_halt, osc_enable}, 2'b11, "stop as wait");
      timer_zero_flag <= 1'b1;
      till(1, 3, n);
      take_irq(3'h3);
      timer_zero_flag <= 1'b0;
      repeat (4) @(posedge aclk);
    end
    {wdg_hw_option, wdg_sw_enable} <= 2'h0;
    $display("test watchdog done");
    timer_zero_flag <= 1'b1;
    till(2, 10, n);
    for (i = 0; i < 2; i++) begin
      cmd(i == 1);
      chk({core_halt, resume_next, osc_enable}, 3'b011, "skipped");
    end
    timer_zero_flag <= 1'b0;
    repeat (4) @(posedge aclk);
    $display("test skip done");
    for (i = 0; i < 2; i++) begin
      core_mode <= i ? MODE_IRQ : MODE_NMI;
      cmd(1'b0);
      timer_zero_flag <= 1'b1;
      till(1, 3, n);
      chk(resume_next, 1, "handler resume");
      repeat (3) @(posedge aclk);
      chk(irq_valid, 0, "no nesting");
      timer_zero_flag <= 1'b0;
      repeat (2) @(posedge aclk);
    end
    cmd(1'b0);
    nmi_pin_n <= 1'b0;
    till(1, 6, n);
    take_irq(3'h0);
    nmi_pin_n <= 1'b1;
    core_mode <= MODE_NORMAL;
    $display("test handler done");
    axi_wr(ADDR_INTERRUPT_OPTION, 8'h00, RESP_OKAY);
    cmd(1'b1);
    nmi_pin_n <= 1'b0;
    repeat (20) @(posedge aclk);
    chk({core_halt, osc_enable}, 2'b10, "no wake");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({core_halt, osc_enable, osc_select}, 3'b010, "reset wake");
    $display("test reset done");
    complete_run();
  end
endmodule
